// [rtl/mcs_regs.sv]
// Register bank for multiplexer channel sequencing
`timescale 1ns/100ps
// Function
// (R1) Mode field 00 manual, 01 on-the-fly, 10 auto, 11 custom sequencing.
// (R2) Config register bit 3 reads the alert pin level, read-only.
// (R3) Config register bit 2 reads 1 on configuration error, else 0.
// (R4) Config bits 7..4 read zero; host must not write them.
// (R5) Config register at 1Ch, resets to 00h (manual mode).
// (R6) Channel field bits 2..0 select analog input 0 through 7.
// (R7) Channel register bits 7..3 read-only zero.
// (R8) Channel register at 1Dh, resets to 00h (input 0).
// (R9) Channel write during running auto/custom sequence aborts it, forces manual.
// (R10) Address 1Eh starts the multiplexer sequence.
// (R11) Address 1Fh aborts the running multiplexer sequence.
// (R12) Address 2Ah enables or disables on-the-fly selection.
// (R13) Address 80h chooses channels taking part in auto sequence.
// (R14) Address 82h controls channel repetition in auto sequence.
// (R15) Start bit 1 begins scan only in auto/custom; 0 never stops.
// (R16) Abort bit 1 stops scan in auto/custom; 0 does nothing.
// (R17) On-the-fly enabled: first five serial input bits pick next channel.
// (R18) Writes to reserved bits are ignored; they keep reading zero.
module mcs_regs
    import mcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic alert_level,
    input wire logic config_error,
    input wire logic frame_start,
    input wire logic serial_data_in,
    output logic [1:0] sequencing_mode_field,
    output logic [2:0] manual_channel,
    output logic sequence_running,
    output logic fast_select_on,
    output logic [4:0] fast_channel,
    output logic fast_channel_valid,
    output logic [7:0] scan_channel_enable,
    output logic [7:0] scan_repeat_ctrl
);
    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    logic wr_cfg, wr_chan, wr_start, wr_stop, wr_fly, wr_scan, wr_rep;
    logic seq_active_mode;
    logic [2:0] fly_count;
    logic [3:0] fly_shift;

    assign wr_cfg = reg_wr && reg_addr == ADDR_SEQUENCER_CONFIG_STATUS; // [R5]
    assign wr_chan = reg_wr && reg_addr == ADDR_MANUAL_CHANNEL_SELECT; // [R8]
    assign wr_start = reg_wr && reg_addr == ADDR_SEQUENCE_START_CTRL; // [R10]
    assign wr_stop = reg_wr && reg_addr == ADDR_SEQUENCE_STOP_CTRL; // [R11]
    assign wr_fly = reg_wr && reg_addr == ADDR_FAST_SELECT_ENABLE; // [R12]
    assign wr_scan = reg_wr && reg_addr == ADDR_SCAN_CHANNEL_ENABLE; // [R13]
    assign wr_rep = reg_wr && reg_addr == ADDR_SCAN_REPEAT_CTRL; // [R14]

    // Start and abort act only in the two sequencing modes
    assign seq_active_mode = sequencing_mode_field == MCS_AUTO || sequencing_mode_field == MCS_CUSTOM; // [R1]

    // ---------------------------------------------------------------
    // Mode field
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sequencing_mode_field <= MODE_RESET; // [R5]
        end else if (wr_chan && sequence_running) begin
            sequencing_mode_field <= MCS_MANUAL; // [R9]
        end else if (wr_cfg) begin
            // Upper data bits are dropped so status and reserved stay fixed
            sequencing_mode_field <= reg_wdata[1:0]; // [R4] [R18]
        end
    end

    // ---------------------------------------------------------------
    // Manual channel select
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            manual_channel <= CHANNEL_RESET; // [R8]
        end else if (wr_chan) begin
            manual_channel <= reg_wdata[2:0]; // [R6] [R18]
        end
    end

    // ---------------------------------------------------------------
    // Sequence run state
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sequence_running <= 1'b0;
        end else if (wr_chan || (wr_cfg && reg_wdata[1:0] != sequencing_mode_field)) begin
            // A mode change also ends a scan so it never runs in manual mode
            sequence_running <= 1'b0; // [R9]
        end else if (wr_stop && reg_wdata[CTRL_BIT] && seq_active_mode) begin
            sequence_running <= 1'b0; // [R16]
        end else if (wr_start && reg_wdata[CTRL_BIT] && seq_active_mode) begin
            sequence_running <= 1'b1; // [R15]
        end
    end

    // ---------------------------------------------------------------
    // Auto sequence and on-the-fly configuration
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fast_select_on <= 1'b0;
        end else if (wr_fly) begin
            fast_select_on <= reg_wdata[CTRL_BIT]; // [R12] [R18]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scan_channel_enable <= BYTE_RESET;
        end else if (wr_scan) begin
            scan_channel_enable <= reg_wdata; // [R13]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scan_repeat_ctrl <= BYTE_RESET;
        end else if (wr_rep) begin
            scan_repeat_ctrl <= reg_wdata; // [R14]
        end
    end

    // ---------------------------------------------------------------
    // On-the-fly capture of the first serial bits of a frame
    // ---------------------------------------------------------------
    // Only the first five bits after frame_start count; later bits are data
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            // Idle until the first frame, so turning the enable on mid-line picks nothing up
            fly_count <= 3'(SERIAL_SEL_BITS);
            fly_shift <= 4'h0;
            fast_channel <= 5'h00;
            fast_channel_valid <= 1'b0;
        end else begin
            fast_channel_valid <= 1'b0;
            if (frame_start) begin
                fly_count <= 3'h0;
            end else if (fast_select_on && fly_count < 3'(SERIAL_SEL_BITS)) begin
                fly_count <= fly_count + 3'h1;
                if (fly_count == 3'(SERIAL_SEL_BITS - 1)) begin
                    fast_channel <= {fly_shift, serial_data_in}; // [R17]
                    fast_channel_valid <= 1'b1;
                end else begin
                    fly_shift <= {fly_shift[2:0], serial_data_in};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SEQUENCER_CONFIG_STATUS:
                    reg_rdata <= {4'h0, alert_level, config_error, sequencing_mode_field}; // [R2] [R3] [R4]
                ADDR_MANUAL_CHANNEL_SELECT:
                    reg_rdata <= {5'h00, manual_channel}; // [R7]
                ADDR_FAST_SELECT_ENABLE:
                    reg_rdata <= {7'h00, fast_select_on};
                ADDR_SCAN_CHANNEL_ENABLE:
                    reg_rdata <= scan_channel_enable;
                ADDR_SCAN_REPEAT_CTRL:
                    reg_rdata <= scan_repeat_ctrl;
                // Start and stop are write-only and read zero
                default:
                    reg_rdata <= UNMAPPED_READ;
            endcase
        end else begin
            reg_rdata <= UNMAPPED_READ;
        end
    end
endmodule

// [pkg/mcs_pkg.sv]
// Package for the multiplexer channel sequence register bank
package mcs_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_SEQUENCER_CONFIG_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_MANUAL_CHANNEL_SELECT = 8'h1D;
    localparam logic [7:0] ADDR_SEQUENCE_START_CTRL = 8'h1E;
    localparam logic [7:0] ADDR_SEQUENCE_STOP_CTRL = 8'h1F;
    localparam logic [7:0] ADDR_FAST_SELECT_ENABLE = 8'h2A;
    localparam logic [7:0] ADDR_SCAN_CHANNEL_ENABLE = 8'h80;
    localparam logic [7:0] ADDR_SCAN_REPEAT_CTRL = 8'h82;
    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int ALERT_BIT = 3;
    localparam int ERROR_BIT = 2;
    localparam int CTRL_BIT = 0;
    localparam int SERIAL_SEL_BITS = 5;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [2:0] CHANNEL_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ---------------------------------------------------------------
    // Sequencing modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MCS_MANUAL = 2'h0,
        MCS_FLY = 2'h1,
        MCS_AUTO = 2'h2,
        MCS_CUSTOM = 2'h3
    } mcs_mode_e;
endpackage

// [verif/mcs_regs_properties.sv]
// Checker for the sequencing register bank ports
`timescale 1ns/100ps
module mcs_regs_properties
    import mcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic alert_level,
    input wire logic config_error,
    input wire logic frame_start,
    input wire logic sequence_running,
    input wire logic fast_select_on,
    input wire logic fast_channel_valid,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] sequencing_mode_field,
    input wire logic [2:0] manual_channel
);
    wire rcfg = reg_rd && reg_addr == 8'h1C;
    wire rch = reg_rd && reg_addr == 8'h1D;
    wire wcfg = reg_wr && reg_addr == 8'h1C;
    wire wch = reg_wr && reg_addr == 8'h1D;
    wire go1 = reg_wr && reg_addr == 8'h1E && reg_wdata[0];
    wire halt1 = reg_wr && reg_addr == 8'h1F && reg_wdata[0];
    wire [1:0] wmode = reg_wdata[1:0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_cfg_read: assert property (rcfg |=> reg_rdata ==
        {4'h0, $past(alert_level), $past(config_error), $past(sequencing_mode_field)}) else $error("cfg read");
    a_chan_read: assert property (rch |=> reg_rdata == {5'h00, $past(manual_channel)}) else $error("chan");
    a_mode_write: assert property (wcfg |=> sequencing_mode_field == $past(wmode)) else $error("mode");
    a_start_scan: assert property (go1 && sequencing_mode_field[1] |=> sequence_running) else $error("go");
    a_start_idle: assert property (go1 && !sequencing_mode_field[1] && !sequence_running
        |=> !sequence_running) else $error("go idle");
    a_stop_scan: assert property (halt1 |=> !sequence_running) else $error("halt");
    a_chan_abort: assert property (wch && sequence_running
        |=> !sequence_running && sequencing_mode_field == 2'h0) else $error("abort");
    a_fly_pick: assert property (fast_select_on && frame_start |-> ##[5:6] fast_channel_valid) else $error("fly");
endmodule
bind mcs_regs mcs_regs_properties u_props (
    .ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .alert_level(alert_level),
    .config_error(config_error), .frame_start(frame_start), .sequence_running(sequence_running),
    .fast_select_on(fast_select_on), .fast_channel_valid(fast_channel_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sequencing_mode_field(sequencing_mode_field),
    .manual_channel(manual_channel)
);

// [verif/mcs_fly_src.sv]
// Serial source that feeds on-the-fly channel picks
`timescale 1ns/100ps
module mcs_fly_src (
    input logic ref_clk,
    input logic go,
    input logic [4:0] sel,
    output logic frame_start = 1'b0,
    output logic serial_data_in = 1'b0
);
    logic [4:0] sh = 5'h00;
    logic [2:0] cnt = 3'h0;
    always @(posedge ref_clk) begin
        frame_start <= go;
        if (go) begin
            sh <= sel;
            cnt <= 3'h5;
        end else if (cnt != 3'h0) begin
            serial_data_in <= sh[4];
            sh <= sh << 1;
            cnt <= cnt - 3'h1;
        end else
            // Idle line toggles so a stray capture shows up
            serial_data_in <= ~serial_data_in;
    end
endmodule

// [verif/mcs_regs_tb.sv]
// Self-checking bench for the sequencing register bank
`timescale 1ns/100ps
module mcs_regs_tb;
    logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, alert_level = 0, config_error = 0, go = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, scan_channel_enable, scan_repeat_ctrl;
    logic [4:0] sel = 0, fast_channel;
    logic [2:0] manual_channel;
    logic [1:0] sequencing_mode_field;
    logic frame_start, serial_data_in, sequence_running, fast_select_on, fast_channel_valid;
    int err_total = 0, check_count = 0;
    always #5 ref_clk = ~ref_clk;
    mcs_regs DUT (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_level(alert_level), .config_error(config_error),
        .frame_start(frame_start), .serial_data_in(serial_data_in),
        .sequencing_mode_field(sequencing_mode_field), .manual_channel(manual_channel),
        .sequence_running(sequence_running), .fast_select_on(fast_select_on), .fast_channel(fast_channel),
        .fast_channel_valid(fast_channel_valid), .scan_channel_enable(scan_channel_enable),
        .scan_repeat_ctrl(scan_repeat_ctrl)
    );
    mcs_fly_src u_src (
        .ref_clk(ref_clk), .go(go), .sel(sel), .frame_start(frame_start), .serial_data_in(serial_data_in)
    );
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Write when w is set, else read and compare with d
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        acc(0, 8'h1C, 8'h00);
        acc(0, 8'h1D, 8'h00);
        for (int m = 0; m < 4; m++) begin
            // Host keeps the reserved config bits at zero
            acc(1, 8'h1C, 8'(m));
            acc(0, 8'h1C, 8'(m));
        end
        for (int n = 0; n < 8; n++) begin
            acc(1, 8'h1D, 8'hF8 | 8'(n));
            chk(manual_channel, 8'(n));
            acc(0, 8'h1D, 8'(n));
        end
        {alert_level, config_error} <= 2'b10;
        acc(0, 8'h1C, 8'h0B);
        {alert_level, config_error} <= 2'b01;
        acc(0, 8'h1C, 8'h07);
        acc(1, 8'h1E, 8'h01);
        chk(sequence_running, 8'h01);
        acc(1, 8'h1E, 8'h00);
        acc(1, 8'h1F, 8'h00);
        chk(sequence_running, 8'h01);
        acc(1, 8'h1F, 8'h01);
        chk(sequence_running, 8'h00);
        acc(1, 8'h1C, 8'h02);
        acc(1, 8'h1E, 8'h01);
        acc(1, 8'h1D, 8'h06);
        chk({sequencing_mode_field, manual_channel, sequence_running}, 8'h0C);
        acc(1, 8'h1E, 8'h01);
        chk(sequence_running, 8'h00);
        acc(0, 8'h81, 8'h00);
        acc(1, 8'h2A, 8'hFF);
        chk(fast_select_on, 8'h01);
        acc(0, 8'h2A, 8'h01);
        acc(1, 8'h80, 8'hA5);
        chk(scan_channel_enable, 8'hA5);
        acc(0, 8'h80, 8'hA5);
        acc(1, 8'h82, 8'h3C);
        chk(scan_repeat_ctrl, 8'h3C);
        acc(0, 8'h82, 8'h3C);
        for (int k = 0; k < 2; k++) begin
            sel <= k ? 5'h09 : 5'h16;
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            // Step past the edge so the strobe of the previous frame is seen cleared
            #1;
            for (int w = 0; w < 9 && fast_channel_valid !== 1'b1; w++)
                @(posedge ref_clk) #1;
            chk({fast_channel_valid, fast_channel}, k ? 8'h29 : 8'h36);
        end
        print_verdict;
    end
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
endmodule
